//--- design/dsc_pkg.sv
/*
  shared constants and types for the dual oscillator clock and standby control block.
  assumes: a 32-bit ahb-lite register bus and a 125 MHz bus clock hclk.
*/
package dsc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, low eight address bits decoded)
  // ----------------------------------------------------------------
  localparam logic [7:0] DSC_MODE_OFS = 8'h00;
  localparam logic [7:0] DSC_STATUS_OFS = 8'h04;
  localparam logic [7:0] DSC_TIMER_OFS = 8'h08;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int DSC_SUBPORT_BIT = 4;
  localparam int DSC_SUBDRIVE_BIT = 5;
  localparam int DSC_MAINHALT_BIT = 6;
  localparam int DSC_SRCSEL_BIT = 7;
  localparam logic [7:0] DSC_MODE_RESET = 8'h00;
  localparam logic [7:0] DSC_MODE_WMASK = 8'hf0;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int DSC_ST_PHI_BIT = 0;
  localparam int DSC_ST_MAINRUN_BIT = 1;
  localparam int DSC_ST_SUBRUN_BIT = 2;
  localparam int DSC_ST_SRCACT_BIT = 3;
  localparam int DSC_ST_HELD_BIT = 4;
  localparam int DSC_ST_IRESET_BIT = 5;
  localparam int DSC_ST_STATE_LSB = 8;

  // ----------------------------------------------------------------
  // timer field positions in the timer register
  // ----------------------------------------------------------------
  localparam int DSC_TM_T3_LSB = 0;
  localparam int DSC_TM_T4_LSB = 8;

  // ----------------------------------------------------------------
  // restart timer: timer 3 cascaded into timer 4, source divided by 16
  // ----------------------------------------------------------------
  localparam logic [7:0] DSC_T3_RELOAD = 8'hff;
  localparam logic [7:0] DSC_T4_RELOAD = 8'h07;
  localparam logic [3:0] DSC_PRESC_LAST = 4'hf;
  localparam logic [3:0] DSC_PRESC_RESET = 4'h0;
  localparam logic [7:0] DSC_COUNT_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam int DSC_HTRANS_ACTIVE_BIT = 1;
  localparam logic DSC_HRESP_OKAY = 1'b0;
  localparam logic [31:0] DSC_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    DSC_RESET_HOLD,
    DSC_RUN,
    DSC_WAIT,
    DSC_STOP_HALT,
    DSC_STOP_RESTART
  } dsc_state_type;

endpackage

//--- design/dsc_osc_sync.sv
/*
  synchroniser for one oscillator input pin, giving a one-cycle tick per rising edge.
  assumes: the oscillator runs well below half of hclk, so no edge is missed.
*/
`timescale 1ns/1ps
module dsc_osc_sync
  import dsc_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic osc_in, // raw oscillator pin
  output logic rise_tick // one cycle per rising edge
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  always_comb begin
    meta_d = osc_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // edge found on the second stage only, never on the metastable one
  assign rise_tick = sync_q & ~prev_q;

endmodule

//--- design/dsc_restart_timer.sv
/*
  oscillation-restart timer: a divide-by-16 prescaler, timer 3 cascaded into timer 4.
  assumes: tick is a one-cycle pulse per source clock edge from the same hclk domain.
*/
`timescale 1ns/1ps
module dsc_restart_timer
  import dsc_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic load, // preset both timers
  input wire logic run, // count enabled
  input wire logic tick, // source clock tick
  output logic [7:0] t3_count, // timer 3 value
  output logic [7:0] t4_count, // timer 4 value
  output logic overflow // one-cycle timer 4 overflow
);

  logic [3:0] presc_q, presc_d;
  logic [7:0] t3_q, t3_d;
  logic [7:0] t4_q, t4_d;
  logic ovf_q, ovf_d;

  always_comb begin
    presc_d = presc_q;
    t3_d = t3_q;
    t4_d = t4_q;
    ovf_d = 1'b0;
    if (load) begin
      presc_d = DSC_PRESC_RESET;
      t3_d = DSC_T3_RELOAD;
      t4_d = DSC_T4_RELOAD;
    end else if (run && tick) begin
      if (presc_q == DSC_PRESC_LAST) begin
        presc_d = DSC_PRESC_RESET;
        // ratio is 1/(n+1): reload on the tick after reaching zero
        if (t3_q == DSC_COUNT_ZERO) begin
          t3_d = DSC_T3_RELOAD;
          if (t4_q == DSC_COUNT_ZERO) begin
            t4_d = DSC_T4_RELOAD;
            ovf_d = 1'b1;
          end else begin
            t4_d = t4_q - 8'h01;
          end
        end else begin
          t3_d = t3_q - 8'h01;
        end
      end else begin
        presc_d = presc_q + 4'h1;
      end
    end
  end

  // reset preset equals the stop preset, so reset needs no load pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= DSC_PRESC_RESET;
      t3_q <= DSC_T3_RELOAD;
      t4_q <= DSC_T4_RELOAD;
      ovf_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      t3_q <= t3_d;
      t4_q <= t4_d;
      ovf_q <= ovf_d;
    end
  end

  assign t3_count = t3_q;
  assign t4_count = t4_q;
  assign overflow = ovf_q;

endmodule

//--- design/dsc_clock_ctrl.sv
/*
  clock generation and standby control: system clock phi as half of the main or sub
  oscillator, stop and wait modes, restart timing and an ahb-lite register slave.
  assumes: a single ahb-lite master, wake requests already enabled and on hclk,
  and a cpu that treats phi as its clock and holds all state while phi stands high.
*/
`timescale 1ns/1ps

// Overview of operation
// - after reset phi is half the main oscillator frequency.
// - mode bit 7 set gives phi from half the sub-clock; clear returns to main.
// - stop instruction halts both oscillators with phi held high.
// - entering stop cascades timers 3 and 4, preset to ff and 07.
// - wake in stop restarts oscillators; phi stays high until timer 4 overflows.
// - wait instruction holds phi high while oscillators keep running.
// - an interrupt in wait resumes phi at once, no settling delay.
// - mode bit 6 set halts the main oscillator; clearing it restarts it.
// - stop released by pin, counter, timer 1/2, serial, key wake interrupts.
// - wait also released by timer 3 and timer 4 interrupts.
// - after reset timers count main/16; internal reset ends at timer 4 overflow.
module dsc_clock_ctrl
  import dsc_pkg::*;
(
  input wire logic hclk, // bus clock, 125 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  output logic [31:0] hrdata, // ahb read data
  input wire logic main_clk_in, // main oscillator pin
  input wire logic sub_clk_in, // sub-clock oscillator pin
  input wire logic stop_instruction, // cpu executes stop, one cycle
  input wire logic wait_instruction, // cpu executes wait, one cycle
  input wire logic ext_irq_a, // external pin a request
  input wire logic ext_irq_b, // external pin b or key request
  input wire logic counter_pin_a, // counter pin a request
  input wire logic counter_pin_b, // counter pin b request
  input wire logic timer1_irq, // timer 1 request
  input wire logic timer2_irq, // timer 2 request
  input wire logic timer3_irq, // timer 3 request
  input wire logic timer4_irq, // timer 4 request
  input wire logic serial_irq, // serial i/o request
  input wire logic key_wake_irq, // key wake-up request
  output logic sys_clk_phi, // internal system clock phi
  output logic sys_clk_held, // phi frozen high in standby
  output logic internal_resetn, // internal reset, active low
  output logic main_osc_run, // main oscillator enabled
  output logic sub_osc_run, // sub-clock oscillator enabled
  output logic sub_osc_high_drive, // sub-clock high drive
  output logic timer_cascade_force, // timers 3/4 forced cascaded
  output logic [7:0] restart_t3, // restart timer 3 value
  output logic [7:0] restart_t4 // restart timer 4 value
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dsc_state_type state_q, state_d;
  logic [7:0] mode_q, mode_d;
  logic phi_q, phi_d;
  logic src_act_q, src_act_d;
  logic iresetn_q, iresetn_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic main_tick, sub_tick, src_tick, restart_tick;
  logic stop_wake, wait_wake;
  logic timer_load, timer_run, timer_ovf;
  logic [7:0] t3_val, t4_val;
  logic phi_gate;
  logic osc_halt_all;
  logic addr_phase;
  logic [7:0] mode_now;

  // ----------------------------------------------------------------
  // oscillator edges and restart timer
  // ----------------------------------------------------------------
  dsc_osc_sync u_main_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_in(main_clk_in),
    .rise_tick(main_tick)
  );

  dsc_osc_sync u_sub_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_in(sub_clk_in),
    .rise_tick(sub_tick)
  );

  // after reset the count source is main/16; in stop it follows the phi source
  assign restart_tick = (state_q == DSC_RESET_HOLD) ? main_tick :
                        (mode_q[DSC_SRCSEL_BIT] ? sub_tick : main_tick);
  assign timer_load = (state_q == DSC_RUN) && stop_instruction;
  assign timer_run = (state_q == DSC_RESET_HOLD) || (state_q == DSC_STOP_RESTART);

  dsc_restart_timer u_restart (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(timer_load),
    .run(timer_run),
    .tick(restart_tick),
    .t3_count(t3_val),
    .t4_count(t4_val),
    .overflow(timer_ovf)
  );

  // ----------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------
  // requests arrive already gated by their enable bits, set by software beforehand
  assign stop_wake = ext_irq_a | ext_irq_b | counter_pin_a | counter_pin_b |
                     timer1_irq | timer2_irq | serial_irq | key_wake_irq;
  assign wait_wake = stop_wake | timer3_irq | timer4_irq;

  // ----------------------------------------------------------------
  // standby state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    iresetn_d = iresetn_q;
    unique case (state_q)
      DSC_RESET_HOLD: begin
        if (timer_ovf) begin
          state_d = DSC_RUN;
          iresetn_d = 1'b1;
        end
      end
      DSC_RUN: begin
        if (stop_instruction) begin
          state_d = DSC_STOP_HALT;
        end else if (wait_instruction) begin
          state_d = DSC_WAIT;
        end
      end
      DSC_WAIT: begin
        if (wait_wake) begin
          state_d = DSC_RUN;
        end
      end
      DSC_STOP_HALT: begin
        if (stop_wake) begin
          state_d = DSC_STOP_RESTART;
        end
      end
      DSC_STOP_RESTART: begin
        if (timer_ovf) begin
          state_d = DSC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= DSC_RESET_HOLD;
      iresetn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      iresetn_q <= iresetn_d;
    end
  end

  // ----------------------------------------------------------------
  // phi generation and source switching
  // ----------------------------------------------------------------
  // phi keeps running during reset hold so the cpu sees clocks before reset ends
  assign phi_gate = (state_q == DSC_WAIT) || (state_q == DSC_STOP_HALT) ||
                    (state_q == DSC_STOP_RESTART);
  assign src_tick = src_act_q ? sub_tick : main_tick;

  always_comb begin
    phi_d = phi_q;
    src_act_d = src_act_q;
    if (src_tick) begin
      if (!phi_q) begin
        phi_d = 1'b1;
      end else if (phi_gate) begin
        phi_d = 1'b1;
      end else if (src_act_q != mode_q[DSC_SRCSEL_BIT]) begin
        // swap while high: the high phase stretches, no pulse is cut short
        src_act_d = mode_q[DSC_SRCSEL_BIT];
      end else begin
        phi_d = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phi_q <= 1'b1;
      src_act_q <= 1'b0;
    end else begin
      phi_q <= phi_d;
      src_act_q <= src_act_d;
    end
  end

  // ----------------------------------------------------------------
  // oscillator controls
  // ----------------------------------------------------------------
  // halt only once phi stands high, else no edge would be left to raise it
  assign osc_halt_all = (state_q == DSC_STOP_HALT) && phi_q;
  assign main_osc_run = !mode_q[DSC_MAINHALT_BIT] && !osc_halt_all;
  assign sub_osc_run = mode_q[DSC_SUBPORT_BIT] && !osc_halt_all;
  assign sub_osc_high_drive = mode_q[DSC_SUBDRIVE_BIT];
  assign timer_cascade_force = (state_q == DSC_RESET_HOLD) ||
                               (state_q == DSC_STOP_HALT) ||
                               (state_q == DSC_STOP_RESTART);
  assign sys_clk_phi = phi_q;
  assign sys_clk_held = phi_gate && phi_q;
  assign internal_resetn = iresetn_q;
  assign restart_t3 = t3_val;
  assign restart_t4 = t4_val;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [7:0] mode);
    logic [31:0] word;
    word = DSC_RDATA_ZERO;
    unique case (addr)
      DSC_MODE_OFS: word[7:0] = mode;
      DSC_STATUS_OFS: begin
        word[DSC_ST_PHI_BIT] = phi_q;
        word[DSC_ST_MAINRUN_BIT] = main_osc_run;
        word[DSC_ST_SUBRUN_BIT] = sub_osc_run;
        word[DSC_ST_SRCACT_BIT] = src_act_q;
        word[DSC_ST_HELD_BIT] = sys_clk_held;
        word[DSC_ST_IRESET_BIT] = iresetn_q;
        word[DSC_ST_STATE_LSB +: 3] = state_q;
      end
      DSC_TIMER_OFS: begin
        word[DSC_TM_T3_LSB +: 8] = t3_val;
        word[DSC_TM_T4_LSB +: 8] = t4_val;
      end
      default: word = DSC_RDATA_ZERO;
    endcase
    return word;
  endfunction

  assign addr_phase = hsel && hready && htrans[DSC_HTRANS_ACTIVE_BIT];

  always_comb begin
    mode_d = mode_q;
    if (wr_pend_q && (wr_addr_q == DSC_MODE_OFS)) begin
      mode_d = hwdata[7:0] & DSC_MODE_WMASK;
    end
  end

  // a read right after a write to the mode register sees the new value
  assign mode_now = mode_d;

  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    rdata_d = rdata_q;
    if (addr_phase) begin
      wr_pend_d = hwrite;
      wr_addr_d = haddr[7:0];
      if (!hwrite) begin
        rdata_d = read_word(haddr[7:0], mode_now);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= DSC_MODE_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= DSC_MODE_OFS;
      rdata_q <= DSC_RDATA_ZERO;
    end else begin
      mode_q <= mode_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait states, always okay; hsize is accepted as word only
  assign hreadyout = 1'b1;
  assign hresp = DSC_HRESP_OKAY;
  assign hrdata = rdata_q;

endmodule

//--- tb/dsc_clock_ctrl_sva.sv
/*
  concurrent checks on the clock and standby control block ports.
  assumes: bound into dsc_clock_ctrl; phi half period is at least three hclk cycles.
*/
`timescale 1ns/1ps
module dsc_clock_ctrl_sva
  import dsc_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // reset, active low
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // slave response
  input wire logic stop_instruction, // stop pulse
  input wire logic wait_instruction, // wait pulse
  input wire logic ext_irq_a, // wake source
  input wire logic ext_irq_b, // wake source
  input wire logic counter_pin_a, // wake source
  input wire logic counter_pin_b, // wake source
  input wire logic timer1_irq, // wake source
  input wire logic timer2_irq, // wake source
  input wire logic timer3_irq, // wait-only wake
  input wire logic timer4_irq, // wait-only wake
  input wire logic serial_irq, // wake source
  input wire logic key_wake_irq, // wake source
  input wire logic sys_clk_phi, // phi
  input wire logic sys_clk_held, // phi frozen
  input wire logic internal_resetn, // internal reset
  input wire logic main_osc_run, // main osc enable
  input wire logic sub_osc_run, // sub osc enable
  input wire logic timer_cascade_force, // timers cascaded
  input wire logic [7:0] restart_t3, // timer 3
  input wire logic [7:0] restart_t4 // timer 4
);
  logic run_st, stop_wake, wait_wake, phi_q, phi_d;
  logic [7:0] len_q, len_d;
  assign run_st = internal_resetn && !timer_cascade_force && !sys_clk_held;
  assign stop_wake = ext_irq_a | ext_irq_b | counter_pin_a | counter_pin_b | timer1_irq |
                     timer2_irq | serial_irq | key_wake_irq;
  assign wait_wake = stop_wake | timer3_irq | timer4_irq;
  // ----------------------------------------------------------------
  // phi half-period length, saturating so long holds never wrap
  // ----------------------------------------------------------------
  always_comb begin
    phi_d = sys_clk_phi;
    len_d = (sys_clk_phi != phi_q) ? 8'h01 : ((len_q == 8'hff) ? len_q : len_q + 8'h01);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phi_q <= 1'b1;
      len_q <= 8'hff;
    end else begin
      phi_q <= phi_d;
      len_q <= len_d;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (
    hreadyout && hresp == DSC_HRESP_OKAY) else $error("bus not ready okay");
  a_held_is_high: assert property (
    sys_clk_held |-> sys_clk_phi) else $error("held phi not high");
  a_reset_cascade: assert property (
    !internal_resetn |-> timer_cascade_force) else $error("reset hold without cascade");
  a_stop_preset: assert property (
    stop_instruction && run_st |=> timer_cascade_force && restart_t3 == DSC_T3_RELOAD &&
    restart_t4 == DSC_T4_RELOAD) else $error("stop entry preset wrong");
  a_stop_osc_halt: assert property (
    stop_instruction && run_st && !stop_wake |=> ##[0:24] (!main_osc_run && !sub_osc_run))
    else $error("oscillators not halted in stop");
  a_wait_held: assert property (
    wait_instruction && !stop_instruction && run_st |=>
    !timer_cascade_force ##[0:24] sys_clk_held) else $error("wait did not hold phi");
  a_wait_osc_on: assert property (
    sys_clk_held && !timer_cascade_force |-> main_osc_run || sub_osc_run)
    else $error("oscillator stopped in wait");
  a_wait_wake: assert property (
    sys_clk_held && !timer_cascade_force && wait_wake |=> !sys_clk_held)
    else $error("wait not released at once");
  a_stop_wake: assert property (
    timer_cascade_force && internal_resetn && !main_osc_run && !sub_osc_run && stop_wake
    |=> main_osc_run || sub_osc_run) else $error("stop wake left oscillators off");
  a_stop_no_timer: assert property (
    timer_cascade_force && internal_resetn && !main_osc_run && !sub_osc_run && !stop_wake &&
    (timer3_irq || timer4_irq) |=> !main_osc_run && !sub_osc_run)
    else $error("timer 3 or 4 released stop");
  a_restart_held: assert property (
    timer_cascade_force && internal_resetn && sys_clk_held |=>
    sys_clk_held || !timer_cascade_force) else $error("phi released before overflow");
  a_phi_no_glitch: assert property (
    sys_clk_phi != phi_q |-> len_q >= 8'h03) else $error("short phi pulse");
  c_stop: cover property (stop_instruction && run_st);
  c_wait_wake: cover property (sys_clk_held && !timer_cascade_force && wait_wake);
  c_stop_wake: cover property (timer_cascade_force && !main_osc_run && stop_wake);
  c_reset_end: cover property ($rose(internal_resetn));
endmodule

bind dsc_clock_ctrl dsc_clock_ctrl_sva sva (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .stop_instruction(stop_instruction),
  .wait_instruction(wait_instruction), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
  .counter_pin_a(counter_pin_a), .counter_pin_b(counter_pin_b), .timer1_irq(timer1_irq),
  .timer2_irq(timer2_irq), .timer3_irq(timer3_irq), .timer4_irq(timer4_irq),
  .serial_irq(serial_irq), .key_wake_irq(key_wake_irq), .sys_clk_phi(sys_clk_phi),
  .sys_clk_held(sys_clk_held), .internal_resetn(internal_resetn),
  .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run),
  .timer_cascade_force(timer_cascade_force), .restart_t3(restart_t3),
  .restart_t4(restart_t4));

//--- tb/dsc_osc_model.sv
/*
  behavioural main and sub oscillators outside the block.
  assumes: a disabled oscillator stands still; edges kept off the hclk edges.
*/
`timescale 1ns/1ps
module dsc_osc_model #(
  parameter int MAIN_HALF_NS = 12,
  parameter int SUB_HALF_NS = 24
) (
  input wire logic main_run, // main enable
  input wire logic sub_run,  // sub enable
  output logic main_clk,     // main pin
  output logic sub_clk       // sub pin
);
  // 3 ns offset keeps every oscillator edge clear of a bus clock edge
  initial begin
    main_clk = 1'b0;
    #3;
    forever #(MAIN_HALF_NS) if (main_run === 1'b1) main_clk = ~main_clk;
  end
  initial begin
    sub_clk = 1'b0;
    #3;
    forever #(SUB_HALF_NS) if (sub_run === 1'b1) sub_clk = ~sub_clk;
  end
endmodule

//--- tb/tb_top.sv
/*
  self-checking bench for the clock and standby control block.
  assumes: oscillator model as the far side; ahb-lite master tasks on hclk.
*/
`timescale 1ns/1ps
module tb_top;
  import dsc_pkg::*;
  localparam int RESTART = 16 * 256 * 8;
  logic hclk, hresetn, hsel, hwrite, stop_i, wait_i, mclk, sclk;
  logic hreadyout, hresp, phi, held, irst, mrun, srun, sdrv, casc;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] irq_v;
  logic [7:0] t3, t4;
  int error_cnt, cmp_count, medges, sedges, n, m, k;
  integer seed = 32'hbcced6fa;

  dsc_clock_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .main_clk_in(mclk),
    .sub_clk_in(sclk), .stop_instruction(stop_i), .wait_instruction(wait_i),
    .ext_irq_a(irq_v[0]), .ext_irq_b(irq_v[1]), .counter_pin_a(irq_v[2]),
    .counter_pin_b(irq_v[3]), .timer1_irq(irq_v[4]), .timer2_irq(irq_v[5]),
    .serial_irq(irq_v[6]), .key_wake_irq(irq_v[7]), .timer3_irq(irq_v[8]),
    .timer4_irq(irq_v[9]), .sys_clk_phi(phi), .sys_clk_held(held),
    .internal_resetn(irst), .main_osc_run(mrun), .sub_osc_run(srun),
    .sub_osc_high_drive(sdrv), .timer_cascade_force(casc), .restart_t3(t3),
    .restart_t4(t4));
  dsc_osc_model osc (.main_run(mrun), .sub_run(srun), .main_clk(mclk), .sub_clk(sclk));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge mclk) medges++;
  always @(posedge sclk) sedges++;

  function automatic logic [31:0] exp_mode(input logic [31:0] d);
    return d & {24'h0, DSC_MODE_WMASK};
  endfunction
  function automatic logic pick(input int sel);
    case (sel)
      0: return held;
      1: return irst;
      2: return mrun;
      default: return phi;
    endcase
  endfunction
  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lapse;
    error_cnt++;
    $display("Error at %0t: wait timed out", $time);
    test_done();
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge hclk);
  endtask
  // samples 1 ns after the edge, once the design has updated
  task automatic wait_on(input int sel, input logic lvl, input int lim);
    int i;
    i = 0;
    @(posedge hclk);
    #1;
    while (pick(sel) !== lvl) begin
      if (i == lim) lapse();
      @(posedge hclk);
      #1;
      i++;
    end
  endtask
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (i == 20) lapse();
      @(posedge hclk);
      i++;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic drive(input logic s, input logic w, input logic [9:0] q);
    @(posedge hclk);
    stop_i <= s;
    wait_i <= w;
    irq_v <= q;
  endtask
  // source edges counted over one full phi period
  task automatic period;
    int a, b;
    wait_on(3, 1'b0, 64);
    wait_on(3, 1'b1, 64);
    a = medges;
    b = sedges;
    wait_on(3, 1'b0, 64);
    wait_on(3, 1'b1, 64);
    n = medges - a;
    m = sedges - b;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    stop_i = 1'b0;
    wait_i = 1'b0;
    irq_v = '0;
    repeat (6) @(posedge hclk);
    #1;
    chk(32'({casc, irst, phi, mrun, srun, t4, t3}), 32'({5'b10110, 16'h07ff}));
    @(posedge hclk);
    hresetn <= 1'b1;
    k = medges;
    wait_on(1, 1'b1, 140000);
    n = medges - k;
    chk(32'(n >= RESTART - 16 && n <= RESTART + 16), 32'h1);
    ahb(1'b0, DSC_MODE_OFS, 32'h0);
    chk(rd, {24'h0, DSC_MODE_RESET});
    for (int i = 0; i < 6; i++) begin
      v = $random(seed) & 32'hffff_ff3f;
      ahb(1'b1, DSC_MODE_OFS, v);
      ahb(1'b0, DSC_MODE_OFS, 32'h0);
      chk(rd, exp_mode(v));
      chk(32'({srun, sdrv}), 32'({v[4], v[5]}));
    end
    ahb(1'b1, 8'h40, $random(seed));
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, DSC_MODE_OFS, 32'h0);
    period();
    chk(n, 2);
    ahb(1'b1, DSC_MODE_OFS, 32'h30);
    tick(50);
    ahb(1'b1, DSC_MODE_OFS, 32'h10);
    ahb(1'b1, DSC_MODE_OFS, 32'h90);
    period();
    period();
    chk(m, 2);
    ahb(1'b1, DSC_MODE_OFS, 32'hd0);
    tick(1);
    chk(mrun, 1'b0);
    period();
    chk(m, 2);
    for (int i = 0; i < 10; i++) begin
      ahb(1'b0, DSC_MODE_OFS, 32'h0);
      v = rd;
      drive(1'b0, 1'b1, 10'h0);
      drive(1'b0, 1'b0, 10'h0);
      wait_on(0, 1'b1, 60);
      tick({$random(seed)} % 8);
      chk(phi, 1'b1);
      drive(1'b0, 1'b0, 10'h1 << i);
      drive(1'b0, 1'b0, 10'h0);
      #1;
      chk(held, 1'b0);
      ahb(1'b0, DSC_MODE_OFS, 32'h0);
      chk(rd, v);
    end
    ahb(1'b1, DSC_MODE_OFS, 32'h90);
    tick(1);
    chk(mrun, 1'b1);
    tick(100);
    ahb(1'b1, DSC_MODE_OFS, 32'h10);
    tick(20);
    ahb(1'b1, DSC_MODE_OFS, 32'h00);
    period();
    chk(n, 2);
    // timers and converter live outside this block
    drive(1'b1, 1'b0, 10'h0);
    drive(1'b0, 1'b0, 10'h0);
    #1;
    chk(32'({casc, t4, t3}), 32'({1'b1, DSC_T4_RELOAD, DSC_T3_RELOAD}));
    wait_on(2, 1'b0, 40);
    chk(32'({srun, held, phi}), 32'h3);
    ahb(1'b0, DSC_TIMER_OFS, 32'h0);
    chk(rd, {16'h0, DSC_T4_RELOAD, DSC_T3_RELOAD});
    ahb(1'b0, DSC_STATUS_OFS, 32'h0);
    chk(rd, (32'(DSC_STOP_HALT) << DSC_ST_STATE_LSB) | 32'h31);
    drive(1'b0, 1'b0, 10'h300);
    drive(1'b0, 1'b0, 10'h0);
    tick(8);
    chk(mrun, 1'b0);
    k = {$random(seed)} % 8;
    drive(1'b0, 1'b0, 10'h1 << k);
    drive(1'b0, 1'b0, 10'h0);
    m = medges;
    wait_on(2, 1'b1, 4);
    wait_on(0, 1'b0, 140000);
    n = medges - m;
    chk(32'(n >= RESTART - 16 && n <= RESTART + 16), 32'h1);
    chk(casc, 1'b0);
    period();
    chk(n, 2);
    test_done();
  end
endmodule
